//--- design/ppfm_top.sv
// Port pin function multiplexer for the six-line port
`timescale 1ns/100ps
module ppfm_top
	import ppfm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       unlock_first_wr,
	input  wire logic       unlock_second_wr,
	input  wire logic [7:0] unlock_wdata,
	input  wire logic       cfg_wr,
	input  wire logic [5:0] cfg_data,
	input  wire logic [5:0] cfg_dir,
	input  wire logic [5:0] cfg_pullup,
	input  wire logic [1:0] cfg_fn0,
	input  wire logic [1:0] cfg_fn2,
	input  wire logic [1:0] cfg_fn5,
	input  wire logic       incircuit_comm_mode,
	input  wire logic       incircuit_comm_data_out,
	input  wire logic       incircuit_comm_data_oe,
	input  wire logic       autoreload_pwm_out,
	input  wire logic [5:0] pin_in,
	output logic      [5:0] pin_out,
	output logic      [5:0] pin_oe,
	output logic      [5:0] pin_pullup,
	output logic      [5:0] pin_analog_en,
	output logic            shared_reset_is_reset,
	output logic            shared_reset_req,
	output logic            analog_channel_zero,
	output logic            analog_channel_two,
	output logic            analog_channel_four,
	output logic            lite_timer_capture_in,
	output logic            external_clock_in,
	output logic            incircuit_comm_clock,
	output logic            incircuit_comm_data,
	output logic      [4:0] ext_irq_lines
);

	logic [5:0] data_r;
	logic [5:0] dir_r;
	logic [5:0] pullup_r;
	ppfm_fn_t   fn0_r;
	ppfm_fn_t   fn2_r;
	ppfm_fn_t   fn5_r;
	logic [5:0] pin_in_r;
	logic [5:0] pin_out_nxt;
	logic [5:0] pin_oe_nxt;
	logic [5:0] pullup_nxt;
	logic [5:0] analog_nxt;

	ppfm_unlock_if ul ();

	assign ul.wr_first  = unlock_first_wr;
	assign ul.wr_second = unlock_second_wr;
	assign ul.wr_data   = unlock_wdata;

	ppfm_unlock u_unlock (
		.clk (clk),
		.rst (rst),
		.ul  (ul)
	);

	// Config registers return to reset values whenever rst is held
	always_ff @(posedge clk) begin
		if (rst) begin
			data_r   <= PPFM_RST_DATA;
			dir_r    <= PPFM_RST_DIR;
			pullup_r <= PPFM_RST_PULLUP;
			fn0_r    <= PPFM_FN_PORT;
			fn2_r    <= PPFM_FN_PORT;
			fn5_r    <= PPFM_FN_PORT;
		end else if (cfg_wr) begin
			data_r   <= cfg_data;
			dir_r    <= cfg_dir;
			pullup_r <= cfg_pullup;
			fn0_r    <= ppfm_fn_t'(cfg_fn0);
			fn2_r    <= ppfm_fn_t'(cfg_fn2);
			fn5_r    <= ppfm_fn_t'(cfg_fn5);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_in_r <= 6'h3F;
		end else begin
			pin_in_r <= pin_in;
		end
	end

	function automatic logic is_analog(input ppfm_fn_t fn);
		return fn == PPFM_FN_ANALOG;
	endfunction

	always_comb begin
		pin_out_nxt = data_r;
		pin_oe_nxt  = dir_r;
		pullup_nxt  = pullup_r & ~dir_r;
		analog_nxt  = 6'h00;
		// Line 0 alternates; comm mode also makes line 1 an input
		if (incircuit_comm_mode) begin
			pin_out_nxt[PPFM_ICC_DATA_IDX] = incircuit_comm_data_out;
			pin_oe_nxt[PPFM_ICC_DATA_IDX]  = incircuit_comm_data_oe;
			pin_oe_nxt[PPFM_ICC_CLK_IDX]   = 1'b0;
		end else if (fn0_r == PPFM_FN_ALT_A) begin
			pin_out_nxt[0] = autoreload_pwm_out;
			pin_oe_nxt[0]  = 1'b1;
		end else if (is_analog(fn0_r)) begin
			pin_oe_nxt[0] = 1'b0;
			analog_nxt[0] = 1'b1;
		end
		if (is_analog(fn2_r)) begin
			pin_oe_nxt[2] = 1'b0;
			analog_nxt[2] = 1'b1;
		end
		if (is_analog(fn5_r)) begin
			pin_oe_nxt[5] = 1'b0;
			analog_nxt[5] = 1'b1;
		end
		// Shared line drives only once unlocked, else stays a reset input
		pin_oe_nxt[PPFM_SHARED_IDX] = ul.unlocked;
		if (!ul.unlocked) begin
			pin_out_nxt[PPFM_SHARED_IDX] = 1'b0;
			pullup_nxt[PPFM_SHARED_IDX]  = 1'b1;
		end
	end

	// Pin controls are registered; forced values hold through reset
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_out       <= PPFM_RST_DATA;
			pin_oe        <= PPFM_RST_DIR;
			pin_pullup    <= PPFM_RST_PULLUP | 6'h08;
			pin_analog_en <= 6'h00;
		end else begin
			pin_out       <= pin_out_nxt;
			pin_oe        <= pin_oe_nxt;
			pin_pullup    <= pullup_nxt;
			pin_analog_en <= analog_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			shared_reset_is_reset <= 1'b1;
			shared_reset_req      <= 1'b0;
		end else begin
			shared_reset_is_reset <= ~ul.unlocked;
			// Low level on the shared line asks for reset while locked
			shared_reset_req      <= ~ul.unlocked & ~pin_in_r[PPFM_SHARED_IDX];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			analog_channel_zero   <= 1'b0;
			analog_channel_two    <= 1'b0;
			analog_channel_four   <= 1'b0;
			lite_timer_capture_in <= 1'b1;
			external_clock_in     <= 1'b0;
			incircuit_comm_clock  <= 1'b1;
			incircuit_comm_data   <= 1'b1;
			ext_irq_lines         <= 5'h00;
		end else begin
			analog_channel_zero   <= pin_in_r[0] & analog_nxt[0];
			analog_channel_two    <= pin_in_r[2] & analog_nxt[2];
			analog_channel_four   <= pin_in_r[5] & analog_nxt[5];
			lite_timer_capture_in <= fn2_r == PPFM_FN_ALT_A ? pin_in_r[2] : 1'b1;
			external_clock_in     <= fn5_r == PPFM_FN_ALT_A ? pin_in_r[5] : 1'b0;
			incircuit_comm_clock  <= pin_in_r[PPFM_ICC_CLK_IDX];
			incircuit_comm_data   <= pin_in_r[PPFM_ICC_DATA_IDX];
			ext_irq_lines         <= {pin_in_r[5], pin_in_r[4], pin_in_r[2:0]};
		end
	end

endmodule

//--- design/ppfm_pkg.sv
// Constants and types for the port pin function multiplexer
package ppfm_pkg;

	localparam int           PPFM_LINES        = 6;
	localparam int           PPFM_SHARED_IDX   = 3;
	localparam int           PPFM_ICC_CLK_IDX  = 1;
	localparam int           PPFM_ICC_DATA_IDX = 0;
	localparam logic [7:0]   PPFM_UNLOCK_FIRST = 8'h55;
	localparam logic [7:0]   PPFM_UNLOCK_SECOND = 8'hAA;
	localparam logic [5:0]   PPFM_RST_DIR      = 6'h00;
	localparam logic [5:0]   PPFM_RST_PULLUP   = 6'h02;
	localparam logic [5:0]   PPFM_RST_DATA     = 6'h00;

	// Alternate function choice per line
	typedef enum logic [1:0] {
		PPFM_FN_PORT,
		PPFM_FN_ANALOG,
		PPFM_FN_ALT_A,
		PPFM_FN_ALT_B
	} ppfm_fn_t;

	typedef enum logic [1:0] {
		PPFM_UL_IDLE,
		PPFM_UL_FIRST_SEEN,
		PPFM_UL_OPEN
	} ppfm_ul_state_t;

endpackage

//--- design/ppfm_unlock_if.sv
// Interface carrying the reset line unlock writes and status
`timescale 1ns/100ps
interface ppfm_unlock_if;
	logic       wr_first;
	logic       wr_second;
	logic [7:0] wr_data;
	logic       unlocked;

	modport ctrl (output wr_first, output wr_second, output wr_data, input unlocked);
	modport lock (input wr_first, input wr_second, input wr_data, output unlocked);
endinterface

//--- design/ppfm_unlock.sv
// Two-value unlock sequencer for the shared reset/port line
`timescale 1ns/100ps
module ppfm_unlock
	import ppfm_pkg::*;
(
	input  wire logic    clk,
	input  wire logic    rst,
	ppfm_unlock_if.lock  ul
);

	ppfm_ul_state_t state_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= PPFM_UL_IDLE;
		end else begin
			case (state_r)
				PPFM_UL_IDLE: begin
					if (ul.wr_first && ul.wr_data == PPFM_UNLOCK_FIRST) begin
						state_r <= PPFM_UL_FIRST_SEEN;
					end
				end
				PPFM_UL_FIRST_SEEN: begin
					// Any other write breaks the sequence
					if (ul.wr_second && ul.wr_data == PPFM_UNLOCK_SECOND) begin
						state_r <= PPFM_UL_OPEN;
					end else if (ul.wr_second || ul.wr_first) begin
						state_r <= PPFM_UL_IDLE;
					end
				end
				default: begin
					state_r <= PPFM_UL_OPEN;
				end
			endcase
		end
	end

	assign ul.unlocked = (state_r == PPFM_UL_OPEN);

endmodule

//--- testbench/ppfm_assertions.sv
// Checker for the port pin function multiplexer
`timescale 1ns/100ps
module ppfm_assertions (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       unlock_second_wr,
	input wire logic [7:0] unlock_wdata,
	input wire logic [5:0] pin_in,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] pin_pullup,
	input wire logic       shared_reset_is_reset,
	input wire logic       shared_reset_req,
	input wire logic [4:0] ext_irq_lines
);
	default clocking @(posedge clk);
	endclocking
	reset_cfg_a: assert property (rst |=> pin_oe == 6'h00 && shared_reset_is_reset)
		else $error("reset configuration wrong");
	comm_pullup_a: assert property (rst |=> pin_pullup[1] && !pin_oe[1])
		else $error("comm clock pin not pulled up");
	locked_nodrive_a: assert property (shared_reset_is_reset |-> !pin_oe[3])
		else $error("shared line driven while reset");
	unlock_order_a: assert property (disable iff (rst) $fell(shared_reset_is_reset) |->
		$past(unlock_second_wr, 2) && $past(unlock_wdata, 2) == 8'hAA)
		else $error("unlock without second value");
	relock_a: assert property (disable iff (rst) $rose(shared_reset_is_reset) |-> $past(rst))
		else $error("relock without reset");
	req_locked_a: assert property (disable iff (rst) shared_reset_req |-> shared_reset_is_reset)
		else $error("reset request while unlocked");
	// Sampled rst in the antecedent: the edge that takes a reset may relock
	open_hold_a: assert property (disable iff (rst)
		!shared_reset_is_reset && !rst |=> !shared_reset_is_reset)
		else $error("unlock lost without reset");
	irq_map_a: assert property (disable iff (rst) !$past(rst) && !$past(rst, 2) |->
		ext_irq_lines == {$past(pin_in[5:4], 2), $past(pin_in[2:0], 2)})
		else $error("interrupt line mapping wrong");
endmodule

bind ppfm_top ppfm_assertions u_ppfm_assertions (.*);

//--- testbench/ppfm_board.sv
// Board model: pin levels from device drivers and outside sources
`timescale 1ns/100ps
module ppfm_board (
	input wire logic [5:0] pin_out,
	input wire logic [5:0] pin_oe,
	input wire logic [5:0] ext_lvl,
	output logic     [5:0] pin_in
);
	// Board pull-up holds line 1 (the comm clock line) high whenever it is not driven
	localparam logic [5:0] BOARD_PU = 6'h02;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_lvl | BOARD_PU));
endmodule

//--- testbench/tb.sv
// Self-checking testbench for the port pin function multiplexer
`timescale 1ns/100ps
module tb;
	import ppfm_pkg::*;
	logic       clk, rst, unlock_first_wr, unlock_second_wr, cfg_wr, incircuit_comm_mode;
	logic       incircuit_comm_data_out, incircuit_comm_data_oe, autoreload_pwm_out;
	logic       shared_reset_is_reset, shared_reset_req, analog_channel_zero;
	logic       analog_channel_two, analog_channel_four, lite_timer_capture_in;
	logic       external_clock_in, incircuit_comm_clock, incircuit_comm_data;
	logic [7:0] unlock_wdata;
	logic [5:0] cfg_data, cfg_dir, cfg_pullup, pin_in, pin_out, pin_oe, pin_pullup;
	logic [5:0] pin_analog_en, ext_lvl;
	logic [1:0] cfg_fn0, cfg_fn2, cfg_fn5;
	logic [4:0] ext_irq_lines;
	int         err_count, cmp_count;
	ppfm_top u_ppfm_top (.*);
	ppfm_board u_ppfm_board (
		.pin_out (pin_out),
		.pin_oe  (pin_oe),
		.ext_lvl (ext_lvl),
		.pin_in  (pin_in)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		// Look just after the edge, once registered outputs have settled
		#1;
	endtask
	task automatic unl(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk);
		unlock_first_wr <= 1'b1;
		unlock_wdata <= a;
		@(posedge clk);
		unlock_first_wr <= 1'b0;
		unlock_second_wr <= 1'b1;
		unlock_wdata <= b;
		@(posedge clk);
		unlock_second_wr <= 1'b0;
		cyc(3);
	endtask
	task automatic cfg(input logic [5:0] d, input logic [5:0] dr, input logic [1:0] f);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_data <= d;
		cfg_dir <= dr;
		{cfg_fn0, cfg_fn2, cfg_fn5} <= {f, f, f};
		@(posedge clk);
		cfg_wr <= 1'b0;
		cyc(3);
	endtask
	task automatic t_unlock();
		cfg(6'h0A, 6'h0A, 2'd0);
		chk("oe3_locked", pin_oe[3], 0);
		unl(8'hAA, 8'hAA);
		chk("bad_first", shared_reset_is_reset, 1);
		unl(8'h55, 8'h5A);
		chk("bad_second", shared_reset_is_reset, 1);
		unl(8'h55, 8'hAA);
		chk("unlocked", shared_reset_is_reset, 0);
		chk("oe3_open", pin_oe[3], 1);
		chk("out3_open", pin_out[3], 1);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		cyc(2);
		chk("relocked", shared_reset_is_reset, 1);
		chk("pullup_rst", pin_pullup, 6'h0A);
		$display("t_unlock done");
	endtask
	task automatic t_mux();
		// Line 1 driven low outside comm mode, so the forced input shows
		cfg(6'h00, 6'h03, 2'd2);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk);
			autoreload_pwm_out <= v[0];
			ext_lvl <= {v[0], 2'b00, v[0], 2'b00};
			cyc(4);
			chk("pwm", pin_out[0], v);
			chk("capture", lite_timer_capture_in, v);
			chk("ext_clk", external_clock_in, v);
			chk("clk_driven", incircuit_comm_clock, 0);
			@(posedge clk);
			incircuit_comm_mode <= 1'b1;
			incircuit_comm_data_oe <= 1'b1;
			incircuit_comm_data_out <= !v[0];
			cyc(4);
			chk("comm_oe", pin_oe[0], 1);
			chk("comm_data", incircuit_comm_data, !v[0]);
			chk("clk_in", pin_oe[1], 0);
			chk("clk_pulled", incircuit_comm_clock, 1);
			@(posedge clk);
			incircuit_comm_mode <= 1'b0;
			ext_lvl <= 6'h25;
		end
		cfg(6'h00, 6'h00, 2'd1);
		chk("analog_en", pin_analog_en, 6'h25);
		chk("analog_zero", analog_channel_zero, 1);
		chk("analog_two", analog_channel_two, 1);
		chk("analog_four", analog_channel_four, 1);
		$display("t_mux done");
	endtask
	task automatic t_irq(input logic [5:0] p);
		@(posedge clk);
		ext_lvl <= p;
		cyc(4);
		chk("irq", ext_irq_lines, {p[5:4], p[2], 1'b1, p[0]});
		chk("req", shared_reset_req, !p[3]);
		$display("t_irq done");
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		{rst, unlock_first_wr, unlock_second_wr, cfg_wr, incircuit_comm_mode} = 5'h10;
		{incircuit_comm_data_out, incircuit_comm_data_oe, autoreload_pwm_out} = 3'h0;
		{unlock_wdata, cfg_data, cfg_dir, cfg_pullup, cfg_fn0, cfg_fn2, cfg_fn5, ext_lvl} = '0;
		cyc(11);
		chk("rst_oe", pin_oe, 6'h00);
		chk("rst_pu", pin_pullup, 6'h0A);
		chk("rst_out", pin_out, 6'h00);
		@(posedge clk);
		rst <= 1'b0;
		t_unlock();
		t_mux();
		cfg(6'h00, 6'h00, 2'd0);
		t_irq(6'h15);
		t_irq(6'h2A);
		stop_test();
	end
	initial begin
		cyc(2000);
		err_count++;
		stop_test();
	end
endmodule
